// >>> core/cpu_regs_defines.svh
// Notes on behaviour
// - Eight 32-bit general registers, address or data.
// - Data access at 32, 16 or 8 bits.
// - Each register splits into upper and lower halves.
// - Lower half splits into high and low bytes.
// - Each register's width chosen independently.
// - Register seven doubles as stack pointer.
// - Program counter is 24 bits wide.
// - Fetch address forces program counter bit zero.
// - Linear 16 Mbyte advanced addressing only.
// - Trace bit resets 0, read/write, no effect.
// - Extended control bits 6..3 read as one.
// - Ext mask field resets ones, no effect.
// - Condition code 8 bits, control instructions access.
// - N, Z, V, C drive branch decisions.
// - Mask bit blocks all but non-maskable interrupt.
// - Exception entry sets condition-code mask bit.
// - Condition code bits 6 and 4 are user bits.
// - Byte arithmetic half-carry from bit 3.
// - Word arithmetic half-carry from bit 11.
// - Longword arithmetic half-carry from bit 27.
// - Negative flag copies result sign bit.
// - Zero flag set when result is zero.
// - Overflow flag marks arithmetic overflow.
// - Carry flag: carry, borrow, shift out, accumulator.
`ifndef CPU_REGS_DEFINES_SVH
`define CPU_REGS_DEFINES_SVH

`define GPR_COUNT 8
`define STACK_GPR_INDEX 3'h7
`define PC_WIDTH 24
`define CCR_MASK_BIT 7
`define CCR_USER_HI_BIT 6
`define CCR_HALF_BIT 5
`define CCR_USER_LO_BIT 4
`define CCR_NEG_BIT 3
`define CCR_ZERO_BIT 2
`define CCR_OVF_BIT 1
`define CCR_CARRY_BIT 0
`define CCR_RESET 8'h80
`define EXR_TRACE_BIT 7
`define EXR_RESERVED 8'h78
`define EXR_RESET 8'h7f
`define EXR_WRITABLE 8'h87
`define HALF_BIT_BYTE 4
`define HALF_BIT_WORD 12
`define HALF_BIT_LONG 28

`endif

// >>> core/cpu_regs_pkg.sv
package cpu_regs_pkg;

    // Access width of a general register view.
    typedef enum logic [1:0] {
        SZ_BYTE = 2'b00,
        SZ_WORD = 2'b01,
        SZ_LONG = 2'b10
    } size_t;

    // Operation applied to a control register by software.
    typedef enum logic [2:0] {
        CTL_NONE = 3'b000,
        CTL_LOAD = 3'b001,
        CTL_AND  = 3'b010,
        CTL_OR   = 3'b011,
        CTL_XOR  = 3'b100
    } ctl_op_t;

    // ALU operation class that decides the flag update.
    typedef enum logic [2:0] {
        ALU_NONE  = 3'b000,
        ALU_ADD   = 3'b001,
        ALU_SUB   = 3'b010,
        ALU_LOGIC = 3'b011,
        ALU_SHIFT = 3'b100
    } alu_class_t;

    // Register view selector: index plus view inside the register.
    // For bytes, upper picks the high byte; for words, the upper half.
    typedef struct packed {
        logic [2:0] index;
        size_t size;
        logic upper;
    } gpr_sel_t;

    // General register write request from the datapath.
    typedef struct packed {
        logic en;
        gpr_sel_t sel;
        logic [31:0] data;
    } gpr_wr_t;

    // Operands and result of one ALU step for flag generation.
    typedef struct packed {
        logic en;
        alu_class_t cls;
        size_t size;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] result;
        logic carry_in;
        logic shift_out;
    } alu_flags_t;

    // Control register request from the control instructions.
    typedef struct packed {
        ctl_op_t op;
        logic to_exr;
        logic [7:0] imm;
    } ctl_req_t;

    // Whole state of the register file.
    typedef struct packed {
        logic [7:0][31:0] gpr;
        logic [23:0] pc;
        logic [7:0] extended_control;
        logic [7:0] condition_code;
        logic [31:0] rd_a;
        logic [31:0] rd_b;
        logic [23:0] fetch_addr;
        logic [7:0] ctl_rd;
        logic [3:0] cond;
        logic irq_ok;
    } regs_state_t;

endpackage

// >>> core/cpu_register_file.sv
`timescale 1ns/10ps
`include "cpu_regs_defines.svh"

module cpu_register_file (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire cpu_regs_pkg::gpr_sel_t i_rd_sel_a,
    input wire cpu_regs_pkg::gpr_sel_t i_rd_sel_b,
    input wire cpu_regs_pkg::gpr_wr_t i_gpr_wr,
    input wire logic i_pc_load,
    input wire logic [23:0] i_pc_value,
    input wire logic i_pc_step,
    input wire cpu_regs_pkg::alu_flags_t i_alu,
    input wire logic i_bit_acc_wr,
    input wire logic i_bit_acc,
    input wire cpu_regs_pkg::ctl_req_t i_ctl,
    input wire logic i_exc_start,
    input wire logic i_irq_maskable,
    input wire logic i_irq_nmi,
    output logic [31:0] o_rd_a,
    output logic [31:0] o_rd_b,
    output logic [31:0] o_stack_ptr,
    output logic [23:0] o_fetch_addr,
    output logic [23:0] o_pc,
    output logic [7:0] o_ctl_rd,
    output logic [7:0] o_ccr,
    output logic [7:0] o_exr,
    output logic [3:0] o_cond,
    output logic o_irq_accept
);
    import cpu_regs_pkg::*;

    regs_state_t r;
    regs_state_t next_r;

    ////////////////////////////////////////////////////////////////////////
    // Read a view of one register, zero extended into 32 bits.
    function automatic logic [31:0] view_read(input logic [7:0][31:0] g,
                                              input gpr_sel_t s);
        logic [31:0] w;
        w = g[s.index];
        unique case (s.size)
            SZ_BYTE: view_read = s.upper ? {24'h00_0000, w[15:8]}
                                         : {24'h00_0000, w[7:0]};
            SZ_WORD: view_read = s.upper ? {16'h0000, w[31:16]}
                                         : {16'h0000, w[15:0]};
            default: view_read = w;
        endcase
    endfunction

    // Merge narrow write data into a register, keeping the rest.
    function automatic logic [31:0] view_merge(input logic [31:0] old,
                                               input gpr_sel_t s,
                                               input logic [31:0] d);
        logic [31:0] w;
        w = old;
        unique case (s.size)
            SZ_BYTE: begin
                if (s.upper) begin
                    w[15:8] = d[7:0];
                end else begin
                    w[7:0] = d[7:0];
                end
            end
            SZ_WORD: begin
                if (s.upper) begin
                    w[31:16] = d[15:0];
                end else begin
                    w[15:0] = d[15:0];
                end
            end
            default: w = d;
        endcase
        view_merge = w;
    endfunction

    // Sign bit position of an operand of the given size.
    function automatic int sign_pos(input size_t s);
        unique case (s)
            SZ_BYTE: sign_pos = 7;
            SZ_WORD: sign_pos = 15;
            default: sign_pos = 31;
        endcase
    endfunction

    // Apply a control instruction to an 8-bit control register.
    function automatic logic [7:0] ctl_apply(input logic [7:0] old,
                                             input ctl_op_t op,
                                             input logic [7:0] imm);
        unique case (op)
            CTL_LOAD: ctl_apply = imm;
            CTL_AND:  ctl_apply = old & imm;
            CTL_OR:   ctl_apply = old | imm;
            CTL_XOR:  ctl_apply = old ^ imm;
            default:  ctl_apply = old;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic for every register and registered output.
    always_comb begin
        logic [32:0] sum;
        logic [31:0] res;
        logic [31:0] mask;
        logic [31:0] bop;
        logic cin;
        logic hc;
        int sp;
        int hb;
        logic [7:0] ctl_val;
        sum = 33'h0_0000_0000;
        res = 32'h0000_0000;
        mask = 32'h0000_0000;
        bop = 32'h0000_0000;
        cin = 1'b0;
        hc = 1'b0;
        sp = 31;
        hb = `HALF_BIT_LONG;
        ctl_val = 8'h00;
        next_r = r;

        if (i_gpr_wr.en) begin
            next_r.gpr[i_gpr_wr.sel.index] =
                view_merge(r.gpr[i_gpr_wr.sel.index], i_gpr_wr.sel,
                           i_gpr_wr.data);
        end

        if (i_pc_load) begin
            next_r.pc = i_pc_value;
        end else if (i_pc_step) begin
            next_r.pc = r.pc + 24'h00_0002;
        end

        // Flag update from the ALU; subtract is done as add of inverse.
        if (i_alu.en && i_alu.cls != ALU_NONE) begin
            sp = sign_pos(i_alu.size);
            unique case (i_alu.size)
                SZ_BYTE: begin
                    mask = 32'h0000_00ff;
                    hb = `HALF_BIT_BYTE;
                end
                SZ_WORD: begin
                    mask = 32'h0000_ffff;
                    hb = `HALF_BIT_WORD;
                end
                default: begin
                    mask = 32'hffff_ffff;
                    hb = `HALF_BIT_LONG;
                end
            endcase
            res = i_alu.result & mask;
            next_r.condition_code[`CCR_NEG_BIT] = res[sp];
            next_r.condition_code[`CCR_ZERO_BIT] = (res == 32'h0000_0000);
            if (i_alu.cls == ALU_ADD || i_alu.cls == ALU_SUB) begin
                bop = (i_alu.cls == ALU_SUB) ? ~i_alu.b : i_alu.b;
                bop = bop & mask;
                cin = (i_alu.cls == ALU_SUB) ? ~i_alu.carry_in
                                             : i_alu.carry_in;
                sum = {1'b0, i_alu.a & mask} + {1'b0, bop} + {32'h0, cin};
                hc = sum[hb] ^ i_alu.a[hb] ^ bop[hb];
                next_r.condition_code[`CCR_HALF_BIT] =
                    (i_alu.cls == ALU_SUB) ? ~hc : hc;
                next_r.condition_code[`CCR_CARRY_BIT] = (i_alu.cls == ALU_SUB)
                    ? ~sum[sp + 1] : sum[sp + 1];
                next_r.condition_code[`CCR_OVF_BIT] =
                    (i_alu.a[sp] == bop[sp]) && (res[sp] != i_alu.a[sp]);
            end else if (i_alu.cls == ALU_SHIFT) begin
                next_r.condition_code[`CCR_CARRY_BIT] = i_alu.shift_out;
                next_r.condition_code[`CCR_OVF_BIT] = 1'b0;
            end else begin
                next_r.condition_code[`CCR_OVF_BIT] = 1'b0;
            end
        end

        if (i_bit_acc_wr) begin
            next_r.condition_code[`CCR_CARRY_BIT] = i_bit_acc;
        end

        if (i_ctl.op != CTL_NONE) begin
            if (i_ctl.to_exr) begin
                ctl_val = ctl_apply(r.extended_control, i_ctl.op, i_ctl.imm);
                next_r.extended_control = (ctl_val & `EXR_WRITABLE) | `EXR_RESERVED;
            end else begin
                next_r.condition_code = ctl_apply(r.condition_code, i_ctl.op, i_ctl.imm);
            end
        end

        // exception entry masks, wins over software
        if (i_exc_start) begin
            next_r.condition_code[`CCR_MASK_BIT] = 1'b1;
        end

        // Read ports see the register state before this cycle's writes.
        next_r.rd_a = view_read(r.gpr, i_rd_sel_a);
        next_r.rd_b = view_read(r.gpr, i_rd_sel_b);
        next_r.fetch_addr = {next_r.pc[23:1], 1'b0};
        next_r.ctl_rd = (i_ctl.to_exr) ? next_r.extended_control : next_r.condition_code;
        next_r.cond = next_r.condition_code[3:0];
        next_r.irq_ok = i_irq_nmi
            || (i_irq_maskable && !next_r.condition_code[`CCR_MASK_BIT]);

        if (i_rst) begin
            // General registers and most flags are left alone by reset.
            next_r.pc = 24'h00_0000;
            next_r.extended_control = `EXR_RESET;
            next_r.condition_code[`CCR_MASK_BIT] = 1'b1;
            next_r.ctl_rd = 8'h00;
            next_r.irq_ok = 1'b0;
            next_r.fetch_addr = 24'h00_0000;
        end
    end

    // State register; reset is folded into the next-state logic above.
    always_ff @(posedge i_clk_sys) begin
        r <= next_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs come straight from the state register.
    assign o_rd_a = r.rd_a;
    assign o_rd_b = r.rd_b;
    assign o_stack_ptr = r.gpr[`STACK_GPR_INDEX];
    assign o_fetch_addr = r.fetch_addr;
    assign o_pc = r.pc;
    assign o_ctl_rd = r.ctl_rd;
    assign o_ccr = r.condition_code;
    assign o_exr = r.extended_control;
    assign o_cond = r.cond;
    assign o_irq_accept = r.irq_ok;

endmodule

// >>> sim/cpu_regs_checker.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////
// Port-level checks of the register file; outputs are tied to their causes.
module cpu_regs_checker (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire cpu_regs_pkg::gpr_wr_t i_gpr_wr,
    input wire logic i_pc_load,
    input wire logic i_pc_step,
    input wire cpu_regs_pkg::alu_flags_t i_alu,
    input wire cpu_regs_pkg::ctl_req_t i_ctl,
    input wire logic i_exc_start,
    input wire logic i_irq_maskable,
    input wire logic i_irq_nmi,
    input wire logic [31:0] o_stack_ptr,
    input wire logic [23:0] o_fetch_addr,
    input wire logic [23:0] o_pc,
    input wire logic [7:0] o_ccr,
    input wire logic [7:0] o_exr,
    input wire logic [3:0] o_cond,
    input wire logic o_irq_accept
);
    import cpu_regs_pkg::*;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);
    property p_exr_res;
        o_exr[6:3] == 4'hf;
    endproperty
    a_exr_res: assert property (p_exr_res)
        else $error("extended control reserved bits not all one");
    property p_exr_load;
        i_ctl.op == CTL_LOAD && i_ctl.to_exr
            |=> o_exr == ($past(i_ctl.imm) | 8'h78);
    endproperty
    a_exr_load: assert property (p_exr_load)
        else $error("extended control load mismatch");
    property p_exc;
        i_exc_start |=> o_ccr[7];
    endproperty
    a_exc: assert property (p_exc)
        else $error("exception entry did not set mask bit");
    property p_pc_step;
        i_pc_step && !i_pc_load |=> o_pc == $past(o_pc) + 24'h00_0002;
    endproperty
    a_pc_step: assert property (p_pc_step)
        else $error("program counter step not two");
    property p_fetch;
        o_fetch_addr == {o_pc[23:1], 1'b0};
    endproperty
    a_fetch: assert property (p_fetch)
        else $error("fetch address bit zero not forced");
    property p_stack;
        i_gpr_wr.en && i_gpr_wr.sel.index == 3'h7
            && i_gpr_wr.sel.size == SZ_LONG
            |=> o_stack_ptr == $past(i_gpr_wr.data);
    endproperty
    a_stack: assert property (p_stack)
        else $error("stack pointer not updated");
    property p_cond;
        i_alu.en |=> o_cond == o_ccr[3:0];
    endproperty
    a_cond: assert property (p_cond)
        else $error("branch condition flags differ from ccr");
    property p_irq;
        !$past(i_rst) |-> o_irq_accept == ($past(i_irq_nmi)
            | ($past(i_irq_maskable) & ~o_ccr[7]));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt acceptance wrong");
    c_exc: cover property (i_exc_start ##1 o_ccr[7]);
    c_half: cover property (i_alu.en ##1 o_ccr[5]);
    c_nmi: cover property (i_irq_nmi ##1 o_irq_accept);
endmodule

bind cpu_register_file cpu_regs_checker chk (.*);

// >>> sim/cpu_datapath_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////
// Behavioural datapath that hands one ALU step to the register file.
module cpu_datapath_model (
    input wire logic i_en,
    input wire cpu_regs_pkg::alu_class_t i_cls,
    input wire cpu_regs_pkg::size_t i_size,
    input wire logic [31:0] i_a,
    input wire logic [31:0] i_b,
    output cpu_regs_pkg::alu_flags_t o_alu
);
    import cpu_regs_pkg::*;
    logic [31:0] raw;
    // Result is cut to operand width, as a narrow ALU would deliver it.
    always_comb begin
        raw = (i_cls == ALU_SUB) ? i_a - i_b : i_a + i_b;
        o_alu = '0;
        o_alu.en = i_en;
        o_alu.cls = i_cls;
        o_alu.size = i_size;
        o_alu.a = i_a;
        o_alu.b = i_b;
        case (i_size)
            SZ_BYTE: o_alu.result = {24'h00_0000, raw[7:0]};
            SZ_WORD: o_alu.result = {16'h0000, raw[15:0]};
            default: o_alu.result = raw;
        endcase
    end
endmodule

// >>> sim/tb_cpu_register_file.sv
`timescale 1ns/10ps
module tb_cpu_register_file;
    import cpu_regs_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    gpr_sel_t sel = '0;
    gpr_wr_t gwr = '0;
    logic pc_load = 1'b0;
    logic [23:0] pc_value = 24'h00_0000;
    logic pc_step = 1'b0;
    logic alu_en = 1'b0;
    size_t alu_size = SZ_BYTE;
    alu_class_t alu_cls = ALU_ADD;
    logic [31:0] alu_a = '0;
    logic bacc_wr = 1'b0;
    ctl_req_t ctl = '0;
    logic exc = 1'b0;
    logic irq_m = 1'b0;
    logic irq_n = 1'b0;
    alu_flags_t alu;
    logic [31:0] rd_a, rd_b, sp;
    logic [23:0] fetch, pc;
    logic [7:0] ctl_rd, condition_code, extended_control;
    logic [3:0] cond;
    logic irq_ok;
    int num_errors = 0;
    int n_tests = 0;
    // Flag cases: half carries, sign and overflow, then two byte subtracts
    // so that borrow out of bit 3 and out of bit 7 are both exercised.
    size_t szs[7] = '{SZ_BYTE, SZ_BYTE, SZ_WORD, SZ_LONG, SZ_LONG, SZ_BYTE,
        SZ_BYTE};
    alu_class_t cls[7] = '{ALU_ADD, ALU_ADD, ALU_ADD, ALU_ADD, ALU_ADD,
        ALU_SUB, ALU_SUB};
    logic [31:0] ops[7] = '{32'h0000_000f, 32'h0000_00ff, 32'h0000_0fff,
        32'h0fff_ffff, 32'h7fff_ffff, 32'h0000_0010, 32'h0000_0000};
    logic [4:0] flg[7] = '{5'h10, 5'h15, 5'h10, 5'h10, 5'h1a, 5'h10,
        5'h19};
    // Control cases: op, target, immediate and expected register value.
    ctl_op_t cop[6] = '{CTL_LOAD, CTL_AND, CTL_OR, CTL_XOR, CTL_LOAD,
        CTL_XOR};
    logic [8:0] cimm[6] = '{9'h050, 9'h040, 9'h01f, 9'h05f, 9'h100, 9'h1ff};
    logic [7:0] cexp[6] = '{8'h50, 8'h40, 8'h5f, 8'h00, 8'h78, 8'hff};

    initial begin
        forever #5 clk = ~clk;
    end

    cpu_datapath_model alu_src (.i_en(alu_en), .i_cls(alu_cls),
        .i_size(alu_size), .i_a(alu_a), .i_b(32'h0000_0001), .o_alu(alu));
    cpu_register_file dut (.i_clk_sys(clk), .i_rst(rst), .i_rd_sel_a(sel),
        .i_rd_sel_b(sel), .i_gpr_wr(gwr), .i_pc_load(pc_load),
        .i_pc_value(pc_value), .i_pc_step(pc_step), .i_alu(alu),
        .i_bit_acc_wr(bacc_wr), .i_bit_acc(1'b1), .i_ctl(ctl),
        .i_exc_start(exc), .i_irq_maskable(irq_m), .i_irq_nmi(irq_n),
        .o_rd_a(rd_a), .o_rd_b(rd_b), .o_stack_ptr(sp),
        .o_fetch_addr(fetch), .o_pc(pc), .o_ctl_rd(ctl_rd), .o_ccr(condition_code),
        .o_exr(extended_control), .o_cond(cond), .o_irq_accept(irq_ok));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    // Each request is held for exactly one rising edge.
    task automatic wr(input logic [3:0] r, input size_t s,
                      input logic [31:0] d);
        gwr = '{1'b1, '{r[2:0], s, r[3]}, d};
        @(negedge clk);
    endtask

    // Read data lags the select by one edge, so look one cycle later.
    task automatic rd(input logic [3:0] r, input size_t s,
                      input logic [31:0] e);
        gwr.en = 1'b0;
        sel = '{r[2:0], s, r[3]};
        @(negedge clk);
        chk("rd_a", e, rd_a);
        chk("rd_b", e, rd_b);
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // The whole run is some forty cycles; this bound is generous.
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        final_report();
    end

    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        chk("exr", 32'h0000_007f, 32'(extended_control));
        chk("mask", 32'h0000_0001, 32'(condition_code[7]));
        chk("pc", 32'h0000_0000, 32'({pc, fetch}));
        wr(4'h2, SZ_LONG, 32'h1234_5678);
        wr(4'ha, SZ_BYTE, 32'h0000_00ab);
        wr(4'ha, SZ_WORD, 32'h0000_cdef);
        wr(4'h5, SZ_BYTE, 32'h0000_0011);
        wr(4'h7, SZ_LONG, 32'h00ff_fffe);
        rd(4'h2, SZ_LONG, 32'hcdef_ab78);
        rd(4'h2, SZ_WORD, 32'h0000_ab78);
        rd(4'ha, SZ_BYTE, 32'h0000_00ab);
        rd(4'h2, SZ_BYTE, 32'h0000_0078);
        rd(4'h5, SZ_BYTE, 32'h0000_0011);
        chk("sp", 32'h00ff_fffe, sp);
        pc_load = 1'b1;
        pc_value = 24'h12_3457;
        @(negedge clk);
        chk("pc", 32'h0012_3457, 32'(pc));
        chk("fetch", 32'h0012_3456, 32'(fetch));
        pc_load = 1'b0;
        pc_step = 1'b1;
        @(negedge clk);
        chk("fetch", 32'h0012_3458, 32'(fetch));
        pc_step = 1'b0;
        // Arithmetic flags, read as {H, N, Z, V, C}.
        for (int i = 0; i < 7; i++) begin
            alu_en = 1'b1;
            alu_cls = cls[i];
            alu_size = szs[i];
            alu_a = ops[i];
            @(negedge clk);
            chk("flags", 32'(flg[i]), 32'({condition_code[5], condition_code[3:0]}));
            chk("cond", 32'(flg[i][3:0]), 32'(cond));
        end
        alu_en = 1'b0;
        bacc_wr = 1'b1;
        @(negedge clk);
        chk("carry", 32'h0000_0001, 32'(condition_code[0]));
        for (int i = 0; i < 6; i++) begin
            bacc_wr = 1'b0;
            ctl = '{cop[i], cimm[i][8], cimm[i][7:0]};
            @(negedge clk);
            chk("ctl", 32'(cexp[i]), 32'(cimm[i][8] ? extended_control : condition_code));
            chk("ctl_rd", 32'(cexp[i]), 32'(ctl_rd));
        end
        ctl.op = CTL_NONE;
        irq_m = 1'b1;
        @(negedge clk);
        chk("irq", 32'h0000_0001, 32'(irq_ok));
        exc = 1'b1;
        @(negedge clk);
        chk("exc", 32'h0000_0080, 32'({condition_code[7], 6'h00, irq_ok}));
        exc = 1'b0;
        irq_n = 1'b1;
        @(negedge clk);
        chk("nmi", 32'h0000_0001, 32'(irq_ok));
        final_report();
    end
endmodule
